// >>> rtl/rtc_params.svh
// Purpose: constants for the relay timer/counter block
// Assumes: 100 MHz scan clock
// Notes: times are in ns, cycle counts derive from them
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define RTC_NUM_TMR 64
`define RTC_NUM_CTR 64
`define RTC_NUM_SEQ 8
`define RTC_SEQ_STEPS 32
`define RTC_IDX_W 6
`define RTC_PV_W 16
`define RTC_STEP_W 16
`define RTC_CLK_NS 10
// one timer unit is a tenth of a second
`define RTC_TICK_NS 100000000
`define RTC_TICK_CYCLES (`RTC_TICK_NS / `RTC_CLK_NS)
`define RTC_TICK_CNT_W 24
`define RTC_PV_RST 16'h0000

`endif

// >>> rtl/rtc_pkg.sv
// Purpose: types shared by the relay timer/counter block
// Assumes: rtc_params.svh defines the sizes
// Notes: none
`include "rtc_params.svh"

package rtc_pkg;

  typedef enum logic [1:0]
  {
    RTC_TMR_IDLE = 2'h0,
    RTC_TMR_TIMING = 2'h1,
    RTC_TMR_EXPIRED = 2'h3
  } rtc_tmr_state_t;

  typedef enum logic [1:0]
  {
    RTC_OP_NONE = 2'h0,
    RTC_OP_SET_PRESET = 2'h1,
    RTC_OP_WR_PRESENT = 2'h2,
    RTC_OP_RD_PRESENT = 2'h3
  } rtc_op_t;

  typedef enum logic
  {
    RTC_TGT_TIMER = 1'h0,
    RTC_TGT_COUNTER = 1'h1
  } rtc_tgt_t;

  typedef struct packed
  {
    rtc_op_t op;
    rtc_tgt_t tgt;
    logic [`RTC_IDX_W-1:0] idx;
    logic [`RTC_PV_W-1:0] value;
  } rtc_cmd_t;

  typedef logic [`RTC_NUM_SEQ-1:0][`RTC_SEQ_STEPS-1:0] rtc_seq_steps_t;

endpackage

// >>> rtl/rtc_top.sv
// Purpose: 64 on-delay timers, 64 down-counters and 8 sequencers as special relays
// Assumes: coils and commands are synchronous to clk; scan_strobe marks one scan
// Notes: contacts and step bits are registered; timer present values in timer units
//
// Notes on behaviour
// - energized timer waits preset before closing
// - expired timer contact closed while coil on
// - coil off opens expired contact immediately
// - coil drop before expiry resets timer
// - re-energized timer restarts from full preset
// - first counter energize loads preset minus one
// - later coil rising edges decrement count
// - held coil causes no further decrements
// - count zero turns counter contact on
// - counter contact stays on regardless of coil
// - only counter reset turns contact off
// - sequencer steps initial to final, wraps
// - sequencer steps 0 to 31 are decodable bits
// - 64 timers, 64 counters, read/write values
// - timer present value counts tenths second
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"

module rtc_top
#(
  parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // scan logic coils
  input wire logic scan_strobe,
  input wire logic [`RTC_NUM_TMR-1:0] tmr_coil,
  input wire logic [`RTC_NUM_CTR-1:0] ctr_coil,
  input wire logic [`RTC_NUM_CTR-1:0] counter_reset_function,
  input wire logic [`RTC_NUM_SEQ-1:0] seq_advance,
  input wire logic [`RTC_NUM_SEQ-1:0] seq_reset,
  // contacts
  output logic [`RTC_NUM_TMR-1:0] tmr_contact,
  output logic [`RTC_NUM_CTR-1:0] ctr_contact,
  output rtc_pkg::rtc_seq_steps_t seq_step,
  // value access
  input wire rtc_pkg::rtc_cmd_t cmd,
  output logic rd_valid,
  output logic [`RTC_PV_W-1:0] rd_data
);
  import rtc_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic arst_n;
  logic [`RTC_TICK_CNT_W-1:0] tick_cnt_ff;
  logic [`RTC_TICK_CNT_W-1:0] nxt_tick_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [`RTC_PV_W-1:0] tmr_pv_ff [`RTC_NUM_TMR];
  logic [`RTC_PV_W-1:0] ctr_pv_ff [`RTC_NUM_CTR];
  logic [`RTC_PV_W-1:0] ctr_sv_ff [`RTC_NUM_CTR];
  logic rd_valid_ff;
  logic nxt_rd_valid;
  logic [`RTC_PV_W-1:0] rd_data_ff;
  logic [`RTC_PV_W-1:0] nxt_rd_data;

  // reset released through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign arst_n = rst_sync_ff;

  always_comb
  begin
    nxt_tick = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + `RTC_TICK_CNT_W'h1;
    if (tick_cnt_ff == `RTC_TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      nxt_tick_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `RTC_NUM_TMR; gi++)
    begin : g_tmr
      rtc_tmr_state_t st_ff;
      rtc_tmr_state_t nxt_st;
      logic coil_ff;
      logic nxt_coil;
      logic contact_ff;
      logic nxt_contact;
      logic [`RTC_PV_W-1:0] sv_ff;
      logic [`RTC_PV_W-1:0] nxt_sv;
      logic [`RTC_PV_W-1:0] nxt_pv;
      logic hit;

      always_comb
      begin
        hit = (cmd.tgt == RTC_TGT_TIMER) && (cmd.idx == `RTC_IDX_W'(gi));
        nxt_st = st_ff;
        nxt_coil = coil_ff;
        nxt_pv = tmr_pv_ff[gi];
        nxt_sv = sv_ff;
        if (tick_ff && st_ff == RTC_TMR_TIMING)
        begin
          if (tmr_pv_ff[gi] <= `RTC_PV_W'h1)
          begin
            nxt_pv = '0;
            nxt_st = RTC_TMR_EXPIRED;
          end
          else
          begin
            nxt_pv = tmr_pv_ff[gi] - `RTC_PV_W'h1;
          end
        end
        if (scan_strobe)
        begin
          nxt_coil = tmr_coil[gi];
          if (!tmr_coil[gi])
          begin
            nxt_st = RTC_TMR_IDLE;
            nxt_pv = '0;
          end
          else if (!coil_ff)
          begin
            nxt_pv = sv_ff;
            nxt_st = (sv_ff == '0) ? RTC_TMR_EXPIRED : RTC_TMR_TIMING;
          end
        end
        if (hit && cmd.op == RTC_OP_SET_PRESET)
        begin
          nxt_sv = cmd.value;
        end
        if (hit && cmd.op == RTC_OP_WR_PRESENT)
        begin
          nxt_pv = cmd.value;
          nxt_st = (cmd.value == '0) ? RTC_TMR_EXPIRED : RTC_TMR_TIMING;
        end
        nxt_contact = (nxt_st == RTC_TMR_EXPIRED);
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          st_ff <= RTC_TMR_IDLE;
          coil_ff <= 1'b0;
          contact_ff <= 1'b0;
          sv_ff <= `RTC_PV_RST;
          tmr_pv_ff[gi] <= `RTC_PV_RST;
        end
        else
        begin
          st_ff <= nxt_st;
          coil_ff <= nxt_coil;
          contact_ff <= nxt_contact;
          sv_ff <= nxt_sv;
          tmr_pv_ff[gi] <= nxt_pv;
        end
      end
      assign tmr_contact[gi] = contact_ff;
    end

    for (gi = 0; gi < `RTC_NUM_CTR; gi++)
    begin : g_ctr
      logic coil_ff;
      logic nxt_coil;
      logic armed_ff;
      logic nxt_armed;
      logic done_ff;
      logic nxt_done;
      logic [`RTC_PV_W-1:0] nxt_pv;
      logic [`RTC_PV_W-1:0] nxt_sv;
      logic hit;

      always_comb
      begin
        hit = (cmd.tgt == RTC_TGT_COUNTER) && (cmd.idx == `RTC_IDX_W'(gi));
        nxt_coil = coil_ff;
        nxt_armed = armed_ff;
        nxt_pv = ctr_pv_ff[gi];
        nxt_sv = ctr_sv_ff[gi];
        if (scan_strobe)
        begin
          nxt_coil = ctr_coil[gi];
          if (ctr_coil[gi] && !coil_ff)
          begin
            // first edge loads preset minus one
            if (!armed_ff)
            begin
              nxt_armed = 1'b1;
              nxt_pv = (ctr_sv_ff[gi] == '0) ? '0 : ctr_sv_ff[gi] - `RTC_PV_W'h1;
            end
            else if (ctr_pv_ff[gi] != '0)
            begin
              nxt_pv = ctr_pv_ff[gi] - `RTC_PV_W'h1;
            end
          end
        end
        if (hit && cmd.op == RTC_OP_SET_PRESET)
        begin
          nxt_sv = cmd.value;
        end
        if (hit && cmd.op == RTC_OP_WR_PRESENT)
        begin
          nxt_pv = cmd.value;
          nxt_armed = 1'b1;
        end
        nxt_done = done_ff || (nxt_armed && nxt_pv == '0);
        // reset is the only way off
        if (counter_reset_function[gi])
        begin
          nxt_armed = 1'b0;
          nxt_done = 1'b0;
          nxt_pv = '0;
        end
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          coil_ff <= 1'b0;
          armed_ff <= 1'b0;
          done_ff <= 1'b0;
          ctr_pv_ff[gi] <= `RTC_PV_RST;
          ctr_sv_ff[gi] <= `RTC_PV_RST;
        end
        else
        begin
          coil_ff <= nxt_coil;
          armed_ff <= nxt_armed;
          done_ff <= nxt_done;
          ctr_pv_ff[gi] <= nxt_pv;
          ctr_sv_ff[gi] <= nxt_sv;
        end
      end
      assign ctr_contact[gi] = done_ff;
    end

    for (gi = 0; gi < `RTC_NUM_SEQ; gi++)
    begin : g_seq
      logic adv_ff;
      logic nxt_adv;
      logic active_ff;
      logic nxt_active;
      logic [`RTC_STEP_W-1:0] step_ff;
      logic [`RTC_STEP_W-1:0] nxt_step;
      logic [`RTC_SEQ_STEPS-1:0] hot_ff;
      logic [`RTC_SEQ_STEPS-1:0] nxt_hot;

      always_comb
      begin
        nxt_adv = adv_ff;
        nxt_active = active_ff;
        nxt_step = step_ff;
        if (scan_strobe)
        begin
          nxt_adv = seq_advance[gi];
          if (seq_advance[gi] && !adv_ff)
          begin
            nxt_active = 1'b1;
            if (!active_ff)
            begin
              nxt_step = (ctr_sv_ff[gi] == '0) ? '0 : `RTC_STEP_W'h1;
            end
            else if (step_ff >= ctr_sv_ff[gi])
            begin
              nxt_step = '0;
            end
            else
            begin
              nxt_step = step_ff + `RTC_STEP_W'h1;
            end
          end
        end
        if (seq_reset[gi])
        begin
          nxt_active = 1'b0;
          nxt_step = '0;
        end
        // one-hot step decode, steps past 31 show none
        nxt_hot = '0;
        if (nxt_active && nxt_step < `RTC_STEP_W'(`RTC_SEQ_STEPS))
        begin
          nxt_hot[nxt_step[4:0]] = 1'b1;
        end
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          adv_ff <= 1'b0;
          active_ff <= 1'b0;
          step_ff <= '0;
          hot_ff <= '0;
        end
        else
        begin
          adv_ff <= nxt_adv;
          active_ff <= nxt_active;
          step_ff <= nxt_step;
          hot_ff <= nxt_hot;
        end
      end
      assign seq_step[gi] = hot_ff;
    end
  endgenerate

  always_comb
  begin
    nxt_rd_valid = (cmd.op == RTC_OP_RD_PRESENT);
    nxt_rd_data = rd_data_ff;
    if (cmd.op == RTC_OP_RD_PRESENT)
    begin
      nxt_rd_data = (cmd.tgt == RTC_TGT_TIMER) ? tmr_pv_ff[cmd.idx] : ctr_pv_ff[cmd.idx];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
    end
    else
    begin
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= nxt_rd_data;
    end
  end
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;

endmodule // rtc_top

`default_nettype wire

// >>> tb/rtc_top_asserts.sv
// Purpose: port checks for rtc_top
// Assumes: bound into every rtc_top
// Notes: one spare cycle allowed where latency is loose
`timescale 1ns/1ps
`default_nettype none
module rtc_top_asserts
#(
  parameter int unsigned TICK_CYCLES = 10
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // inputs
  input wire logic scan_strobe,
  input wire logic [63:0] tmr_coil,
  input wire logic [63:0] counter_reset_function,
  input wire logic [7:0] seq_reset,
  input wire rtc_pkg::rtc_cmd_t cmd,
  // outputs
  input wire logic [63:0] tmr_contact,
  input wire logic [63:0] ctr_contact,
  input wire rtc_pkg::rtc_seq_steps_t seq_step,
  input wire logic rd_valid
);
  import rtc_pkg::*;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_tmr_drop;
    scan_strobe |-> ##2 (tmr_contact & ~$past(tmr_coil, 2)) == 64'h0;
  endproperty
  a_tmr_drop: assert property (p_tmr_drop) else $error("timer contact held");
  property p_ctr_hold;
    (~ctr_contact & $past(ctr_contact) & ~$past(counter_reset_function)
      & ~$past(counter_reset_function, 2)) == 64'h0;
  endproperty
  a_ctr_hold: assert property (p_ctr_hold) else $error("counter contact lost");
  property p_ctr_clr;
    counter_reset_function != 64'h0 |=>
      (ctr_contact & $past(counter_reset_function)) == 64'h0;
  endproperty
  a_ctr_clr: assert property (p_ctr_clr) else $error("counter not cleared");
  property p_ctr_set;
    (ctr_contact & ~$past(ctr_contact)) != 64'h0 |-> $past(scan_strobe) || $past(scan_strobe, 2);
  endproperty
  a_ctr_set: assert property (p_ctr_set) else $error("counter set off scan");
  property p_seq_oh;
    $onehot0(seq_step[0]);
  endproperty
  a_seq_oh: assert property (p_seq_oh) else $error("step not one-hot");
  property p_seq_move;
    seq_step != $past(seq_step) |-> $past(scan_strobe) || $past(scan_strobe, 2)
      || $past(seq_reset) != 8'h0 || $past(seq_reset, 2) != 8'h0;
  endproperty
  a_seq_move: assert property (p_seq_move) else $error("step moved off scan");
  property p_rd_ans;
    cmd.op == RTC_OP_RD_PRESENT |=> rd_valid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_src;
    rd_valid |-> $past(cmd.op) == RTC_OP_RD_PRESENT;
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("stray read answer");
  c_ctr: cover property (ctr_contact != 64'h0);
  c_tmr: cover property (tmr_contact != 64'h0);
  c_seq: cover property (seq_step[0][0]);
endmodule // rtc_top_asserts
bind rtc_top rtc_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) rtc_top_asserts_i
(
  .clk, .nrst, .scan_strobe, .tmr_coil, .counter_reset_function, .seq_reset, .cmd,
  .tmr_contact, .ctr_contact, .seq_step, .rd_valid
);
`default_nettype wire

// >>> tb/rtc_scan_model.sv
// Purpose: scan pacing of the controller side
// Assumes: coils themselves come from the bench
// Notes: one strobe every SCAN clocks, first one well after reset
`timescale 1ns/1ps
`default_nettype none
module rtc_scan_model
#(
  parameter int unsigned SCAN = 5
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // scan pacing
  output logic scan_strobe
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  always_comb
  begin
    nxt_cnt = (cnt_ff == 8'(SCAN - 1)) ? 8'h0 : cnt_ff + 8'h1;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= 8'h0;
    else
      cnt_ff <= nxt_cnt;
  end
  assign scan_strobe = nrst && (cnt_ff == 8'(SCAN - 1));
endmodule // rtc_scan_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for rtc_top
// Assumes: ten clocks per tick, one scan every five clocks
// Notes: read answers are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtc_pkg::*;
  logic clk, nrst, scan_strobe, rd_valid;
  logic [15:0] rd_data, v;
  logic [63:0] tmr_coil, ctr_coil, counter_reset_function, tmr_contact, ctr_contact;
  logic [7:0] seq_advance, seq_reset;
  logic [5:0] ti, ci;
  rtc_seq_steps_t seq_step;
  rtc_cmd_t cmd;
  logic [31:0] seed = 32'h726DF4B1;
  logic [15:0] exp_q[$];
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  rtc_scan_model #(.SCAN(5)) rtc_scan_model_i (.clk, .nrst, .scan_strobe);
  rtc_top #(.TICK_CYCLES(10)) rtc_top_i
  (
    .clk, .nrst, .scan_strobe, .tmr_coil, .ctr_coil, .counter_reset_function, .seq_advance,
    .seq_reset, .tmr_contact, .ctr_contact, .seq_step, .cmd, .rd_valid, .rd_data
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] e);
    compares++;
    if (seen !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobe is sampled mid-cycle to avoid racing its own edge
  task automatic scan(int n);
    repeat (n)
    begin
      do @(negedge clk); while (scan_strobe !== 1'b1);
      @(posedge clk);
    end
    #1;
  endtask
  // idle cycle after each command keeps one assignment per time step
  task automatic put(rtc_op_t op, rtc_tgt_t tg, logic [5:0] ix, logic [15:0] val);
    cmd = '{op, tg, ix, val};
    cyc(1);
    cmd = '0;
    cyc(1);
  endtask
  task automatic rd(rtc_tgt_t tg, logic [5:0] ix, logic [15:0] e);
    exp_q.push_back(e);
    put(RTC_OP_RD_PRESENT, tg, ix, 16'h0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (rd_valid === 1'b1)
      chk("rd_data", 64'(rd_data), 64'(exp_q.pop_front()));
    if (cycles == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    {nrst, tmr_coil, ctr_coil, counter_reset_function, seq_advance, seq_reset} = '0;
    cmd = '0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    cyc(3);
    ti = 6'(rnd());
    ci = 6'(rnd());
    v = 16'(rnd()) | 16'h1;
    put(RTC_OP_SET_PRESET, RTC_TGT_COUNTER, ci, 16'h3);
    for (int k = 2; k >= 0; k--)
    begin
      ctr_coil[ci] = 1'b1;
      scan(2);
      rd(RTC_TGT_COUNTER, ci, 16'(k));
      ctr_coil[ci] = 1'b0;
      scan(1);
    end
    chk("ctr_contact", ctr_contact, 64'h1 << ci);
    ctr_coil[ci] = 1'b1;
    scan(2);
    chk("ctr_contact", ctr_contact, 64'h1 << ci);
    counter_reset_function[ci] = 1'b1;
    cyc(1);
    counter_reset_function[ci] = 1'b0;
    cyc(2);
    chk("ctr_contact", ctr_contact, 64'h0);
    ctr_coil[ci] = 1'b0;
    put(RTC_OP_WR_PRESENT, RTC_TGT_COUNTER, ci, v);
    rd(RTC_TGT_COUNTER, ci, v);
    put(RTC_OP_SET_PRESET, RTC_TGT_TIMER, ti, 16'h4);
    tmr_coil[ti] = 1'b1;
    scan(1);
    cyc(15);
    tmr_coil[ti] = 1'b0;
    scan(1);
    // wait past latest expiry of dropped run
    cyc(21);
    chk("tmr_contact", tmr_contact, 64'h0);
    rd(RTC_TGT_TIMER, ti, 16'h0);
    tmr_coil[ti] = 1'b1;
    scan(1);
    cyc(28);
    chk("tmr_contact", tmr_contact, 64'h0);
    cyc(15);
    chk("tmr_contact", tmr_contact, 64'h1 << ti);
    scan(2);
    chk("tmr_contact", tmr_contact, 64'h1 << ti);
    tmr_coil[ti] = 1'b0;
    scan(1);
    cyc(1);
    chk("tmr_contact", tmr_contact, 64'h0);
    // written 2 expires one to two ticks on
    tmr_coil[ti] = 1'b1;
    scan(1);
    put(RTC_OP_WR_PRESENT, RTC_TGT_TIMER, ti, 16'h2);
    cyc(9);
    chk("tmr_contact", tmr_contact, 64'h0);
    cyc(10);
    chk("tmr_contact", tmr_contact, 64'h1 << ti);
    tmr_coil[ti] = 1'b0;
    scan(1);
    put(RTC_OP_SET_PRESET, RTC_TGT_COUNTER, 6'h0, 16'h2);
    for (int k = 1; k < 5; k++)
    begin
      seq_advance[0] = 1'b1;
      scan(1);
      seq_advance[0] = 1'b0;
      scan(1);
      chk("seq_step", 64'(seq_step[0]), 64'h1 << (k % 3));
    end
    seq_reset[0] = 1'b1;
    cyc(1);
    seq_reset[0] = 1'b0;
    cyc(2);
    chk("seq_step", 64'(seq_step[0]), 64'h0);
    cyc(3);
    chk("queue", 64'(exp_q.size()), 64'h0);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
